// [common/fifo_pkg.sv]
// Purpose: Shared constants for the host FIFO subsystem.
// Assumes: One 40 MHz clock, 32-bit host words, byte offsets on the host address.
// Notes: Sizes are in bytes unless the name says words; the TX size limits and reset value are in KB.
package fifo_pkg;
  // ---------------------------------------------------------------
  // Host address map
  // ---------------------------------------------------------------
  localparam logic [7:0] RX_DATA_BASE = 8'h00;
  localparam logic [7:0] TX_DATA_BASE = 8'h20;
  localparam logic [7:0] DATA_ALIAS_MASK = 8'hE0;
  localparam logic [7:0] RX_STATUS_POP_OFS = 8'h40;
  localparam logic [7:0] RX_STATUS_PEEK_OFS = 8'h44;
  localparam logic [7:0] TX_STATUS_POP_OFS = 8'h48;
  localparam logic [7:0] TX_STATUS_PEEK_OFS = 8'h4C;
  // ---------------------------------------------------------------
  // Pool allocation
  // ---------------------------------------------------------------
  localparam int POOL_BYTES = 16384;
  localparam int KB_BYTES = 1024;
  localparam int TX_STATUS_BYTES = 512;
  localparam int RX_STATUS_DIV = 16;
  localparam int TX_MIL_BYTES = 2048;
  localparam int RX_MIL_BYTES = 128;
  localparam int RX_FULL_MARGIN_WORDS = 4;
  localparam logic [3:0] TX_SIZE_RESET = 4'h5;
  localparam logic [3:0] TX_SIZE_MIN = 4'h2;
  localparam logic [3:0] TX_SIZE_MAX = 4'hE;
  // Word counts: 13-bit fields cover the 4096-word pool.
  localparam int CNT_W = 13;
  localparam int POOL_WORDS = POOL_BYTES / 4;
  localparam int TX_STATUS_WORDS = TX_STATUS_BYTES / 4;
  localparam int TX_MIL_WORDS = TX_MIL_BYTES / 4;
  localparam int RX_MIL_WORDS = RX_MIL_BYTES / 4;
endpackage : fifo_pkg

// [rtl/word_fifo.sv]
// Purpose: Word FIFO over a fixed array with a run-time limit on occupancy.
// Assumes: limit never exceeds DEPTH and changes only while the FIFO is empty.
// Notes: Peek shows the oldest word combinationally from the array.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int DEPTH = 4096
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [12:0] limit,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic pop,
  output logic [31:0] head,
  output logic [12:0] count,
  output logic empty,
  output logic full
);
  import fifo_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [31:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [12:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // Pushes into a full FIFO and pops from an empty one are dropped.
  always_comb begin
    do_push = push && (cnt_q < limit);
    do_pop = pop && (cnt_q != 13'h0000);
    wr_d = do_push ? wr_q + 1'b1 : wr_q;
    rd_d = do_pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {12'h000, do_push} - {12'h000, do_pop};
  end

  // Pointer state.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= 13'h0000;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Array storage has no reset, which keeps it mappable to RAM.
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_q] <= push_data;
    end
  end

  assign head = mem[rd_q];
  assign count = cnt_q;
  assign empty = (cnt_q == 13'h0000);
  assign full = (cnt_q >= limit);

  // A push in the same cycle still lands, so only that push may show in the count.
  a_no_underflow: assert property (@(posedge clock) disable iff (!resetn)
    empty && pop |=> count == {12'h000, $past(push)}) else $error("pop changed empty fifo");
endmodule : word_fifo
`default_nettype wire

// [rtl/host_mac_fifo_subsystem.sv]
// Purpose: Host FIFO subsystem between the host bus and the MAC TX/RX logic.
// Assumes: Single clock; host accesses are one-cycle strobes with read data registered for the next cycle.
// Notes: The size field is sampled only on size_load while paths are idle; reset loads TX_SIZE_RESET.
`timescale 1ns/1ps
`default_nettype none
module host_mac_fifo_subsystem (
  input wire logic clock,
  input wire logic resetn,
  // Host bus interface.
  input wire logic [7:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  input wire logic direct_select,
  input wire logic [3:0] tx_allocation_size_field,
  input wire logic size_load,
  // MAC transmit side.
  output logic mac_tx_valid,
  output logic [31:0] mac_tx_data,
  output logic mac_tx_last,
  input wire logic mac_tx_ready,
  input wire logic tx_frame_end,
  input wire logic tx_status_valid,
  input wire logic [31:0] tx_status_word,
  // MAC receive side, drop count and data levels.
  input wire logic mac_rx_valid,
  input wire logic [31:0] mac_rx_data,
  input wire logic mac_rx_last,
  input wire logic rx_status_valid,
  input wire logic [31:0] rx_status_word,
  output logic [31:0] rx_drop_count,
  output logic [12:0] tx_data_level,
  output logic [12:0] rx_data_level
);
  import fifo_pkg::*;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic in_window(input logic [7:0] a, input logic [7:0] base);
    in_window = (a & DATA_ALIAS_MASK) == base;
  endfunction : in_window

  logic rx_data_rd, tx_data_wr, rxs_pop, rxs_peek, txs_pop, txs_peek;
  always_comb begin
    rx_data_rd = host_rd && (direct_select || in_window(host_addr, RX_DATA_BASE));
    tx_data_wr = host_wr && (direct_select || in_window(host_addr, TX_DATA_BASE));
    rxs_pop = host_rd && !direct_select && host_addr == RX_STATUS_POP_OFS;
    txs_pop = host_rd && !direct_select && host_addr == TX_STATUS_POP_OFS;
    rxs_peek = host_rd && !direct_select && host_addr == RX_STATUS_PEEK_OFS;
    txs_peek = host_rd && !direct_select && host_addr == TX_STATUS_PEEK_OFS;
  end

  // ---------------------------------------------------------------
  // Allocation
  // ---------------------------------------------------------------
  logic [3:0] size_q, size_d;
  logic [12:0] tx_total_w, rx_total_w, txd_lim, rxs_lim, rxd_lim, rxd_full_lim;
  logic paths_idle;

  // Reserved values are clamped so the pool can never be overcommitted.
  always_comb begin
    size_d = size_q;
    if (size_load && paths_idle) begin
      if (tx_allocation_size_field < TX_SIZE_MIN) begin
        size_d = TX_SIZE_MIN;
      end else if (tx_allocation_size_field > TX_SIZE_MAX) begin
        size_d = TX_SIZE_MAX;
      end else begin
        size_d = tx_allocation_size_field;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      size_q <= TX_SIZE_RESET;
    end else begin
      size_q <= size_d;
    end
  end

  // Word limits derived from the size field.
  always_comb begin
    tx_total_w = 13'(int'(size_q) * (KB_BYTES / 4));
    txd_lim = tx_total_w - 13'(TX_STATUS_WORDS);
    rx_total_w = 13'(POOL_WORDS) - tx_total_w;
    rxs_lim = rx_total_w / 13'(RX_STATUS_DIV);
    rxd_lim = rx_total_w - rxs_lim;
    rxd_full_lim = rxd_lim - 13'(RX_FULL_MARGIN_WORDS);
  end

  // ---------------------------------------------------------------
  // Host FIFOs
  // ---------------------------------------------------------------
  logic [31:0] txd_head, rxd_head, txs_head, rxs_head;
  logic [12:0] txd_cnt, rxd_cnt, txs_cnt, rxs_cnt;
  logic txd_empty, rxd_empty, txs_empty, rxs_empty, txd_full, rxd_full, txs_full, rxs_full;
  logic txd_pop, rxd_push, milr_pop;
  logic [31:0] milr_head;

  // Command words and payload share this FIFO; no distinction is made here.
  word_fifo #(.DEPTH(POOL_WORDS)) u_tx_data (
    .clock(clock), .resetn(resetn), .limit(txd_lim), .push(tx_data_wr),
    .push_data(host_wdata), .pop(txd_pop), .head(txd_head), .count(txd_cnt),
    .empty(txd_empty), .full(txd_full)
  );
  word_fifo #(.DEPTH(POOL_WORDS)) u_rx_data (
    .clock(clock), .resetn(resetn), .limit(rxd_full_lim), .push(rxd_push),
    .push_data(milr_head), .pop(rx_data_rd), .head(rxd_head), .count(rxd_cnt),
    .empty(rxd_empty), .full(rxd_full)
  );
  word_fifo #(.DEPTH(TX_STATUS_WORDS)) u_tx_status (
    .clock(clock), .resetn(resetn), .limit(13'(TX_STATUS_WORDS)), .push(tx_status_valid),
    .push_data(tx_status_word), .pop(txs_pop), .head(txs_head), .count(txs_cnt),
    .empty(txs_empty), .full(txs_full)
  );
  word_fifo #(.DEPTH(POOL_WORDS / RX_STATUS_DIV)) u_rx_status (
    .clock(clock), .resetn(resetn), .limit(rxs_lim), .push(rx_status_valid),
    .push_data(rx_status_word), .pop(rxs_pop), .head(rxs_head), .count(rxs_cnt),
    .empty(rxs_empty), .full(rxs_full)
  );

  // Read data mux; empty FIFOs and unmapped addresses read as zero.
  logic [31:0] rdata_d, rdata_q;
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rx_data_rd && !rxd_empty) rdata_d = rxd_head;
    else if ((rxs_pop || rxs_peek) && !rxs_empty) rdata_d = rxs_head;
    else if ((txs_pop || txs_peek) && !txs_empty) rdata_d = txs_head;
  end

  always_ff @(posedge clock) begin
    if (!resetn) rdata_q <= 32'h0000_0000;
    else rdata_q <= rdata_d;
  end
  assign host_rdata = rdata_q;

  // ---------------------------------------------------------------
  // MAC layer TX buffer: store and forward
  // ---------------------------------------------------------------
  logic [32:0] milt_mem [TX_MIL_WORDS];
  logic [9:0] milt_wr_q, milt_wr_d, milt_rd_q, milt_rd_d;
  logic [1:0] frames_q, frames_d;
  logic milt_push, milt_pop, milt_room;

  // Frame ends are tagged in bit 32; at most two complete frames are tracked.
  always_comb begin
    milt_room = (milt_wr_q - milt_rd_q) < 10'(TX_MIL_WORDS);
    milt_push = !txd_empty && milt_room && frames_q != 2'h2;
    txd_pop = milt_push;
    mac_tx_valid = frames_q != 2'h0;
    milt_pop = mac_tx_valid && mac_tx_ready;
    milt_wr_d = milt_push ? milt_wr_q + 1'b1 : milt_wr_q;
    milt_rd_d = milt_pop ? milt_rd_q + 1'b1 : milt_rd_q;
    frames_d = frames_q + {1'b0, milt_push && tx_frame_end}
               - {1'b0, milt_pop && mac_tx_last};
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      milt_wr_q <= 10'h000;
      milt_rd_q <= 10'h000;
      frames_q <= 2'h0;
    end else begin
      milt_wr_q <= milt_wr_d;
      milt_rd_q <= milt_rd_d;
      frames_q <= frames_d;
    end
  end

  always_ff @(posedge clock) begin
    if (milt_push) milt_mem[milt_wr_q[8:0]] <= {tx_frame_end, txd_head};
  end
  assign mac_tx_data = milt_mem[milt_rd_q[8:0]][31:0];
  assign mac_tx_last = milt_mem[milt_rd_q[8:0]][32];

  // ---------------------------------------------------------------
  // MAC layer RX buffer and drop counter
  // ---------------------------------------------------------------
  logic [31:0] milr_mem [RX_MIL_WORDS];
  logic [5:0] milr_wr_q, milr_wr_d, milr_rd_q, milr_rd_d;
  logic [31:0] drop_q, drop_d;
  logic dropping_q, dropping_d, milr_push, milr_empty;

  // A frame is cut at its first refused word: the rest of it is discarded and counted as one drop.
  always_comb begin
    milr_empty = milr_wr_q == milr_rd_q;
    milr_pop = !milr_empty && !rxd_full;
    rxd_push = milr_pop;
    milr_push = mac_rx_valid && !dropping_q && !rxd_full &&
                (milr_wr_q - milr_rd_q) < 6'(RX_MIL_WORDS);
    dropping_d = dropping_q;
    drop_d = drop_q;
    if (mac_rx_valid && !milr_push && !dropping_q) begin
      drop_d = drop_q + 32'h0000_0001;
      dropping_d = !mac_rx_last;
    end else if (mac_rx_valid && mac_rx_last) begin
      dropping_d = 1'b0;
    end
    milr_wr_d = milr_push ? milr_wr_q + 1'b1 : milr_wr_q;
    milr_rd_d = milr_pop ? milr_rd_q + 1'b1 : milr_rd_q;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      milr_wr_q <= 6'h00;
      milr_rd_q <= 6'h00;
      drop_q <= 32'h0000_0000;
      dropping_q <= 1'b0;
    end else begin
      milr_wr_q <= milr_wr_d;
      milr_rd_q <= milr_rd_d;
      drop_q <= drop_d;
      dropping_q <= dropping_d;
    end
  end

  always_ff @(posedge clock) begin
    if (milr_push) milr_mem[milr_wr_q[4:0]] <= mac_rx_data;
  end
  assign milr_head = milr_mem[milr_rd_q[4:0]];

  assign paths_idle = txd_empty && rxd_empty && txs_empty && rxs_empty &&
                      milr_empty && milt_wr_q == milt_rd_q;
  assign rx_drop_count = drop_q;
  assign tx_data_level = txd_cnt;
  assign rx_data_level = rxd_cnt;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_alloc_sum: assert property (@(posedge clock) disable iff (!resetn)
    32'(tx_total_w) + 32'(rx_total_w) == 32'(POOL_WORDS)) else $error("pool split wrong");
  a_tx_min: assert property (@(posedge clock) disable iff (!resetn)
    tx_total_w >= 13'(2 * KB_BYTES / 4)) else $error("tx total below 2KB");
  a_rxs_ratio: assert property (@(posedge clock) disable iff (!resetn)
    32'(rxs_lim) * 16 == 32'(rx_total_w)) else $error("rx status not 1/16");
  a_reset_size: assert property (@(posedge clock) $rose(resetn) |-> size_q == TX_SIZE_RESET)
    else $error("reset allocation wrong");
  a_rx_margin: assert property (@(posedge clock) disable iff (!resetn)
    rxd_cnt <= rxd_lim - 13'h0004) else $error("rx data past margin");
  a_peek_keeps: assert property (@(posedge clock) disable iff (!resetn)
    rxs_peek && !rx_status_valid |=> $stable(rxs_cnt)) else $error("peek popped");
  a_pop_takes: assert property (@(posedge clock) disable iff (!resetn)
    txs_pop && !txs_empty && !tx_status_valid |=> txs_cnt == $past(txs_cnt) - 13'h0001)
    else $error("pop did not remove");
  // A frame may only be offered while the buffer really holds its words.
  a_sf_gate: assert property (@(posedge clock) disable iff (!resetn)
    mac_tx_valid |-> milt_wr_q != milt_rd_q) else $error("tx before frame complete");
  a_drop_count: assert property (@(posedge clock) disable iff (!resetn)
    mac_rx_valid && rxd_full && !dropping_q |=> rx_drop_count == $past(rx_drop_count) + 1)
    else $error("drop not counted");
  a_alias_hit: assert property (@(posedge clock) disable iff (!resetn)
    host_wr && host_addr[7:5] == 3'h1 |-> tx_data_wr) else $error("alias missed");
  a_direct_sel: assert property (@(posedge clock) disable iff (!resetn)
    direct_select && host_rd |-> rx_data_rd) else $error("direct read misrouted");
  c_drop: cover property (@(posedge clock) disable iff (!resetn) drop_d != drop_q);
  c_tx_frame: cover property (@(posedge clock) disable iff (!resetn) milt_pop && mac_tx_last);
  c_two_frames: cover property (@(posedge clock) disable iff (!resetn) frames_q == 2'h2);
  c_peek_pop: cover property (@(posedge clock) disable iff (!resetn) rxs_peek ##2 rxs_pop);
endmodule : host_mac_fifo_subsystem
`default_nettype wire

// [test/mac_side_model.sv]
// Purpose: Behavioural MAC side of the host FIFO block: TX sink, RX source, status pulses.
// Assumes: Outputs change at the falling clock edge only.
// Notes: Released data lines show the inverse of the last word, never a stale copy.
`timescale 1ns/1ps
`default_nettype none
module mac_side_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic slow,
  input wire logic mac_tx_valid,
  input wire logic [31:0] mac_tx_data,
  input wire logic mac_tx_last,
  output logic mac_tx_ready,
  output logic mac_rx_valid,
  output logic [31:0] mac_rx_data,
  output logic mac_rx_last,
  output logic tx_status_valid,
  output logic [31:0] tx_status_word,
  output logic rx_status_valid,
  output logic [31:0] rx_status_word
);
  logic [32:0] got_q[$];
  // All outputs start idle so the block sees no stray request.
  initial begin
    {mac_tx_ready, mac_rx_valid, mac_rx_data, mac_rx_last} = '0;
    {tx_status_valid, tx_status_word, rx_status_valid, rx_status_word} = '0;
  end
  // A slow sink drops ready every other cycle, so each word must be held.
  always @(negedge clock) begin
    mac_tx_ready <= slow ? ~mac_tx_ready : 1'b1;
  end
  // Words are taken with their frame-end flag on the accepting edge.
  always @(posedge clock) begin
    if (resetn && mac_tx_valid && mac_tx_ready) begin
      got_q.push_back({mac_tx_last, mac_tx_data});
    end
  end
  // Words follow back to back; the receive side has no back-pressure.
  task automatic send_frame(input int n, input logic [31:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      mac_rx_valid = 1'b1;
      mac_rx_data = base + 32'(i);
      mac_rx_last = (i == n - 1);
    end
    @(negedge clock);
    mac_rx_valid = 1'b0;
    mac_rx_last = 1'b0;
    mac_rx_data = ~mac_rx_data;
  endtask : send_frame
  // One status word is pushed with a single-cycle pulse.
  task automatic push_status(input bit to_tx, input logic [31:0] w);
    @(negedge clock);
    {tx_status_valid, rx_status_valid} = to_tx ? 2'b10 : 2'b01;
    tx_status_word = w;
    rx_status_word = w;
    @(negedge clock);
    {tx_status_valid, rx_status_valid} = 2'b00;
    tx_status_word = ~w;
    rx_status_word = ~w;
  endtask : push_status
endmodule : mac_side_model
`default_nettype wire

// [test/host_mac_fifo_subsystem_tb.sv]
// Purpose: Self-checking bench for the host FIFO subsystem.
// Assumes: Inputs change at the falling edge; host strobes come every other cycle.
// Notes: Fills at sizes 2, 5 and 14 dominate run time, some six thousand cycles.
`timescale 1ns/1ps
`default_nettype none
module host_mac_fifo_subsystem_tb;
  import fifo_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] host_addr = 8'h00;
  logic host_rd = 1'b0;
  logic host_wr = 1'b0;
  logic [31:0] host_wdata = 32'h0000_0000;
  logic direct_select = 1'b0;
  logic [3:0] tx_allocation_size_field = TX_SIZE_RESET;
  logic size_load = 1'b0;
  logic tx_frame_end = 1'b0;
  logic slow = 1'b0;
  logic [31:0] host_rdata, mac_tx_data, mac_rx_data, tx_status_word, rx_status_word;
  logic [31:0] rx_drop_count;
  logic mac_tx_valid, mac_tx_last, mac_tx_ready, mac_rx_valid, mac_rx_last;
  logic tx_status_valid, rx_status_valid;
  logic [12:0] tx_data_level, rx_data_level;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 clock = ~clock;
  host_mac_fifo_subsystem dut (.clock, .resetn, .host_addr, .host_rd, .host_wr, .host_wdata,
    .host_rdata, .direct_select, .tx_allocation_size_field, .size_load, .mac_tx_valid,
    .mac_tx_data, .mac_tx_last, .mac_tx_ready, .tx_frame_end, .tx_status_valid,
    .tx_status_word, .mac_rx_valid, .mac_rx_data, .mac_rx_last, .rx_status_valid,
    .rx_status_word, .rx_drop_count, .tx_data_level, .rx_data_level);
  mac_side_model mac (.clock, .resetn, .slow, .mac_tx_valid, .mac_tx_data, .mac_tx_last,
    .mac_tx_ready, .mac_rx_valid, .mac_rx_data, .mac_rx_last, .tx_status_valid,
    .tx_status_word, .rx_status_valid, .rx_status_word);
  // A hang is cut short so that a stuck handshake still ends in a verdict.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // ----------------------------------------------------------------
  // Host and setup helpers
  // ----------------------------------------------------------------
  // The frame-end tag stays put after the write, while the word is at the head.
  task automatic host_write(input logic [7:0] a, input logic [31:0] d, input bit fe);
    @(negedge clock);
    host_addr = a;
    host_wdata = d;
    tx_frame_end = fe;
    host_wr = 1'b1;
    @(negedge clock);
    host_wr = 1'b0;
  endtask : host_write
  // Read data is registered at the read edge and settled by the next falling edge.
  task automatic read_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(negedge clock);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clock);
    host_rd = 1'b0;
    check(what, host_rdata, exp);
  endtask : read_check
  task automatic do_reset();
    @(negedge clock);
    resetn = 1'b0;
    repeat (16) @(negedge clock);
    resetn = 1'b1;
    check("read data", host_rdata, 32'h0000_0000);
    check("tx valid", 32'(mac_tx_valid), 32'h0000_0000);
    check("levels", 32'({tx_data_level, rx_data_level}), 32'h0000_0000);
    check("drops", rx_drop_count, 32'h0000_0000);
  endtask : do_reset
  task automatic load_size(input logic [3:0] sz);
    @(negedge clock);
    tx_allocation_size_field = sz;
    size_load = 1'b1;
    @(negedge clock);
    size_load = 1'b0;
  endtask : load_size
  task automatic wait_rx(input int lvl);
    for (int i = 0; i < 200 && rx_data_level !== 13'(lvl); i++) @(negedge clock);
  endtask : wait_rx
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_tx_alias();
    slow = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i == 7) begin
        @(negedge clock);
        check("tx early", 32'(mac_tx_valid), 32'h0000_0000);
        check("tx level", 32'(tx_data_level), 32'h0000_0000);
      end
      host_write(TX_DATA_BASE + 8'(4 * i), 32'hA5A5_0000 + 32'(i), i == 7);
    end
    for (int k = 0; k < 100 && mac.got_q.size() < 8; k++) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      check("tx word", mac.got_q[i][31:0], 32'hA5A5_0000 + 32'(i));
      check("tx last", 32'(mac.got_q[i][32]), 32'(i == 7));
    end
    mac.got_q.delete();
    slow = 1'b0;
  endtask : t_tx_alias
  task automatic t_rx_alias();
    mac.send_frame(8, 32'h5A00_0010);
    wait_rx(8);
    for (int i = 0; i < 8; i++) begin
      read_check("rx alias", RX_DATA_BASE + 8'(4 * i), 32'h5A00_0010 + 32'(i));
    end
    mac.send_frame(2, 32'h5A00_0020);
    wait_rx(2);
    direct_select = 1'b1;
    read_check("direct read", TX_STATUS_POP_OFS, 32'h5A00_0020);
    read_check("direct read", RX_STATUS_PEEK_OFS, 32'h5A00_0021);
    host_write(RX_STATUS_POP_OFS, 32'h0C0C_0001, 1'b1);
    direct_select = 1'b0;
    for (int k = 0; k < 100 && mac.got_q.size() < 1; k++) @(negedge clock);
    check("direct write", mac.got_q[0][31:0], 32'h0C0C_0001);
    mac.got_q.delete();
  endtask : t_rx_alias
  // Peek, pop and an empty pop on each status FIFO; index 3 means empty.
  task automatic t_status();
    int ofs[7] = '{4, 4, 0, 0, 4, 0, 0};
    int idx[7] = '{0, 0, 0, 1, 2, 2, 3};
    logic [7:0] pop;
    logic [31:0] exp;
    for (int k = 0; k < 2; k++) begin
      pop = (k == 1) ? TX_STATUS_POP_OFS : RX_STATUS_POP_OFS;
      for (int i = 0; i < 3; i++) mac.push_status(k == 1, 32'h0057_0000 + 32'(16 * k + i));
      for (int i = 0; i < 7; i++) begin
        exp = (idx[i] == 3) ? 32'h0000_0000 : 32'h0057_0000 + 32'(16 * k + idx[i]);
        read_check("status", pop + 8'(ofs[i]), exp);
      end
    end
    read_check("unmapped", 8'h60, 32'h0000_0000);
  endtask : t_status
  // Fill RX data to its full mark in 4-word frames, then two frames must be lost.
  task automatic rx_fill(input logic [3:0] sz, input bit load);
    int lim;
    lim = (POOL_BYTES - int'(sz) * KB_BYTES) * (RX_STATUS_DIV - 1) / RX_STATUS_DIV / 4
      - RX_FULL_MARGIN_WORDS;
    do_reset();
    if (load) begin
      load_size(sz);
    end
    for (int f = 0; f < lim / 4; f++) mac.send_frame(4, 32'(4 * f));
    wait_rx(lim);
    check("rx full level", 32'(rx_data_level), 32'(lim));
    check("drops", rx_drop_count, 32'h0000_0000);
    mac.send_frame(4, 32'hDEAD_0000);
    mac.send_frame(4, 32'hDEAD_0004);
    for (int k = 0; k < 20 && rx_drop_count !== 32'h0000_0002; k++) @(negedge clock);
    check("drops", rx_drop_count, 32'h0000_0002);
    check("rx level kept", 32'(rx_data_level), 32'(lim));
    read_check("rx head", RX_DATA_BASE, 32'h0000_0000);
  endtask : rx_fill
  // An unfinished frame fills the MAC buffer, then TX data fills to its share.
  task automatic tx_fill(input logic [3:0] sz);
    int cap;
    cap = (int'(sz) * KB_BYTES - TX_STATUS_BYTES) / 4;
    do_reset();
    load_size(sz);
    for (int i = 0; i < TX_MIL_WORDS + cap + 4; i++) host_write(TX_DATA_BASE, 32'(i), 1'b0);
    check("tx full level", 32'(tx_data_level), 32'(cap));
    check("tx held", 32'(mac_tx_valid), 32'h0000_0000);
  endtask : tx_fill
  // The whole sequence; a reset between fills also checks the default size.
  initial begin
    do_reset();
    t_tx_alias();
    t_rx_alias();
    t_status();
    rx_fill(TX_SIZE_RESET, 1'b0);
    rx_fill(TX_SIZE_MAX, 1'b1);
    tx_fill(TX_SIZE_MIN);
    report_and_stop();
  end
endmodule : host_mac_fifo_subsystem_tb
`default_nettype wire
